// File: shared/ppm_consts.vh
// Constants for the port power management register bank.
// Assumes configuration accesses arrive as dword-aligned byte addresses.
`ifndef PPM_CONSTS_VH
`define PPM_CONSTS_VH
`define PPM_CAP_ADDR 12'h0c0
`define PPM_CSR_ADDR 12'h0c4
`define PPM_CAP_ID 8'h01
`define PPM_NXT_UP 8'h00
`define PPM_NXT_DN 8'hd0
`define PPM_VER 3'h3
`define PPM_SUPPORT_RST 5'h19
`define PPM_PS_D0 2'h0
`define PPM_PS_D3HOT 2'h3
`define PPM_CTX_RST 1'h1
`define PPM_PS_LSB 0
`define PPM_CTX_BIT 3
`define PPM_EN_BIT 8
`define PPM_ST_BIT 15
`define PPM_DEVICE_SPECIFIC_INIT_BIT 21
`define PPM_SUP_LSB 27
`endif

// File: hdl/ppm_wake_sync.v
// Three-stage synchroniser for one level from outside the clock domain.
// Assumes the input is quasi-static relative to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module ppm_wake_sync (
  input wire clk_sys_i,
  input wire rst_i,
  input wire async_i,
  output reg level_o
);
  reg s1;
  reg s2;
  reg s3;
  ////////////////////////////////////////////////////////////////////////////
  // Stage one feeds stage two only; level moves when stages two and three agree
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end
endmodule // ppm_wake_sync
`default_nettype wire

// File: hdl/ppm_regs.v
// Power management capability and control/status registers of one port.
// Assumes a single-cycle configuration access port; reads return next cycle.
`timescale 1ns/1ps
`default_nettype none
`include "ppm_consts.vh"
module ppm_regs #(
  parameter IS_UPSTREAM = 0
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire hot_rst_i,
  input wire cfg_wr_i,
  input wire cfg_rd_i,
  input wire [11:0] cfg_addr_i,
  input wire [31:0] cfg_wdata_i,
  input wire [3:0] cfg_be_i,
  input wire write_lock_open_i,
  input wire port_wake_event_i,
  input wire fwd_wake_msg_i,
  input wire d3cold_i,
  output reg [31:0] cfg_rdata_o,
  output reg cfg_rvalid_o,
  output wire [1:0] power_state_o,
  output wire context_preserve_o,
  output wire context_reset_o,
  output wire wake_msg_send_o,
  output wire wake_msg_forward_o
);
  reg [1:0] power_state_field;
  reg context_preserve_bit;
  reg wake_event_enable;
  reg wake_event_status;
  reg [4:0] wake_state_support;
  reg device_specific_init;
  reg ctx_reset_pulse;
  wire d3cold_sync;
  wire wr_cap;
  wire wr_csr;
  wire st_clear;
  wire own_event;
  wire [31:0] cap_word;
  wire [31:0] csr_word;

  ////////////////////////////////////////////////////////////////////////////
  // D3cold comes from the power controller, outside this clock domain
  ppm_wake_sync u_cold_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(d3cold_i),
    .level_o(d3cold_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign wr_cap = cfg_wr_i && (cfg_addr_i == `PPM_CAP_ADDR);
  assign wr_csr = cfg_wr_i && (cfg_addr_i == `PPM_CSR_ADDR);
  assign st_clear = wr_csr && cfg_be_i[1] && cfg_wdata_i[`PPM_ST_BIT];
  // Upstream port never raises its own event
  assign own_event = port_wake_event_i && (IS_UPSTREAM == 0);

  ////////////////////////////////////////////////////////////////////////////
  // Non-sticky fields: loaded with their reset values by power-on and hot reset alike
  always @(posedge clk_sys_i) begin
    if (rst_i || hot_rst_i) begin
      power_state_field <= `PPM_PS_D0;
      context_preserve_bit <= `PPM_CTX_RST;
      wake_state_support <= `PPM_SUPPORT_RST;
      device_specific_init <= 1'b0;
      ctx_reset_pulse <= 1'b0;
    end else begin
      ctx_reset_pulse <= 1'b0;
      // Reserved D1/D2 codes are dropped so the field never reports them
      if (wr_csr && cfg_be_i[0]) begin
        if (cfg_wdata_i[1:0] == `PPM_PS_D0 || cfg_wdata_i[1:0] == `PPM_PS_D3HOT) begin
          power_state_field <= cfg_wdata_i[1:0];
          // D3hot to D0 without preservation requests a context reset
          if (power_state_field == `PPM_PS_D3HOT && cfg_wdata_i[1:0] == `PPM_PS_D0
              && !context_preserve_bit) begin
            ctx_reset_pulse <= 1'b1;
          end
        end
        if (write_lock_open_i) begin
          context_preserve_bit <= cfg_wdata_i[`PPM_CTX_BIT];
        end
      end
      // Support mask is advertised only; event logic never reads it
      if (wr_cap && write_lock_open_i) begin
        if (cfg_be_i[3]) begin
          wake_state_support <= cfg_wdata_i[31:27];
        end
        if (cfg_be_i[2]) begin
          device_specific_init <= cfg_wdata_i[`PPM_DEVICE_SPECIFIC_INIT_BIT];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky bits: only the power-on reset touches them, not hot reset
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      wake_event_enable <= 1'b0;
      wake_event_status <= 1'b0;
    end else begin
      if (wr_csr && cfg_be_i[1]) begin
        wake_event_enable <= cfg_wdata_i[`PPM_EN_BIT];
      end
      // Set wins over a same-cycle write-one clear
      if (own_event) begin
        wake_event_status <= 1'b1;
      end else if (st_clear) begin
        wake_event_status <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read words; unimplemented fields are constant zero
  // D2, D1 and aux current take bits 26:22; reserved and event clock take 20:19
  assign cap_word = {wake_state_support, 5'h00, device_specific_init, 2'h0, `PPM_VER,
    (IS_UPSTREAM != 0) ? `PPM_NXT_UP : `PPM_NXT_DN, `PPM_CAP_ID};
  assign csr_word = {8'h00, 2'h0, 6'h00, wake_event_status, 6'h00, wake_event_enable,
    4'h0, context_preserve_bit, 1'b0, power_state_field};

  // Read data registered; unmapped addresses return zero
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_rdata_o <= 32'h00000000;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_rd_i;
      if (cfg_rd_i) begin
        if (cfg_addr_i == `PPM_CAP_ADDR) begin
          cfg_rdata_o <= cap_word;
        end else if (cfg_addr_i == `PPM_CSR_ADDR) begin
          cfg_rdata_o <= csr_word;
        end else begin
          cfg_rdata_o <= 32'h00000000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the port's message logic
  assign power_state_o = power_state_field;
  assign context_preserve_o = context_preserve_bit;
  assign context_reset_o = ctx_reset_pulse;
  assign wake_msg_send_o = own_event && wake_event_enable && !d3cold_sync;
  // Forwarding stops in D3cold; the system must route wake around the switch
  assign wake_msg_forward_o = fwd_wake_msg_i && !d3cold_sync;
endmodule // ppm_regs
`default_nettype wire

// File: verif/ppm_regs_properties.sv
// Concurrent checks on the ports of the power management register bank.
// Assumes it is bound into every ppm_regs instance.
`timescale 1ns/1ps
`default_nettype none
module ppm_regs_props #(parameter IS_UPSTREAM = 0) (
  input wire logic clk_sys_i, rst_i, cfg_rd_i, cfg_wr_i, port_wake_event_i, fwd_wake_msg_i,
  input wire logic d3cold_i, cfg_rvalid_o, context_preserve_o, context_reset_o,
  input wire logic wake_msg_send_o, wake_msg_forward_o,
  input wire logic [11:0] cfg_addr_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic [1:0] power_state_o
);
  // One clock domain, so clock and reset are named once
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire rc = cfg_rd_i && cfg_addr_i == 12'h0c4;
  wire rp = cfg_rd_i && cfg_addr_i == 12'h0c0;
  //////////////////////////////////////////////////////////////////////////////
  // Register views; a read answers one cycle later with the state it saw
  state_legal_a: assert property (power_state_o != 2'h1 && power_state_o != 2'h2)
    else $error("reserved state");
  csr_mirror_a: assert property (rc |=> cfg_rvalid_o && cfg_rdata_o[3:0] ==
    {$past(context_preserve_o), 1'h0, $past(power_state_o)}) else $error("bad csr view");
  csr_zero_a: assert property (rc |=> cfg_rdata_o[31:16] == 16'h0
    && cfg_rdata_o[14:9] == 6'h0 && cfg_rdata_o[7:4] == 4'h0 && !cfg_rdata_o[2]) else $error("csr");
  cap_fixed_a: assert property (rp |=> cfg_rdata_o[18:16] == 3'h3
    && cfg_rdata_o[20:19] == 2'h0 && cfg_rdata_o[26:22] == 5'h0) else $error("cap fixed");
  // An own event, a cycle with no write-one clear, then a read must show the status
  own_status_a: assert property (port_wake_event_i ##1 !cfg_wr_i ##1 rc
    |=> cfg_rdata_o[15] == (IS_UPSTREAM == 0)) else $error("wake status");
  cold_block_a: assert property (d3cold_i [*8] |-> !wake_msg_send_o && !wake_msg_forward_o)
    else $error("sent in d3cold");
  warm_pass_a: assert property (!d3cold_i [*8] |-> wake_msg_forward_o == fwd_wake_msg_i)
    else $error("forward lost");
  // The same write may also reload the preserve bit, so judge the value it replaced
  ctx_reset_a: assert property (context_reset_o |-> power_state_o == 2'h0
    && $past(power_state_o) == 2'h3 && !$past(context_preserve_o)) else $error("context reset");
  cover property (context_reset_o);
  cover property (wake_msg_send_o);
  cover property (rc ##1 cfg_rdata_o[15]);
endmodule // ppm_regs_props
bind ppm_regs ppm_regs_props #(.IS_UPSTREAM(IS_UPSTREAM)) u_props (.*);
`default_nettype wire

// File: verif/test_port_power_mgmt_regs.sv
// Bench for the power management register bank, downstream instance.
// Assumes the bound checker; inputs change 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module test_port_power_mgmt_regs;
  logic clk_sys_i = 0, rst_i = 1, hot_rst_i = 0, cfg_wr_i = 0, cfg_rd_i = 0, d3cold_i = 0;
  logic write_lock_open_i = 0, port_wake_event_i = 0, fwd_wake_msg_i = 0;
  logic [11:0] cfg_addr_i = 0;
  logic [31:0] cfg_wdata_i = 0, cfg_rdata_o;
  logic [3:0] cfg_be_i = 0;
  logic [1:0] power_state_o, s = 0, n;
  logic cfg_rvalid_o, context_preserve_o, context_reset_o, wake_msg_send_o, wake_msg_forward_o;
  int err_total = 0, checked = 0, cyc = 0;
  ppm_regs i_dut (.*);
  initial forever #2 clk_sys_i = ~clk_sys_i;
  //////////////////////////////////////////////////////////////////////////////
  // Expected control/status word built from its fields
  function automatic logic [31:0] csr(logic [1:0] p, logic c, e, t);
    return {16'h0, t, 6'h0, e, 4'h0, c, 1'h0, p};
  endfunction
  task automatic chk(input logic [32:0] g, e);
    checked++;
    err_total += int'(g !== e);
    if (g !== e) $display("[FAIL] %0t got %h exp %h", $time, g, e);
  endtask
  // One access with an idle cycle after; a read checks valid and data
  task automatic acc(input logic w, logic [11:0] a, logic [31:0] d, logic [3:0] b);
    @(posedge clk_sys_i);
    #1 {cfg_wr_i, cfg_rd_i, cfg_addr_i, cfg_wdata_i, cfg_be_i} = {w, !w, a, d, b};
    @(posedge clk_sys_i);
    #1 {cfg_wr_i, cfg_rd_i} = 2'h0;
    if (!w) chk({cfg_rvalid_o, cfg_rdata_o}, {1'h1, d});
  endtask
  // Own event for one cycle; send is combinational so it is seen at once
  task automatic wake(input logic e);
    @(posedge clk_sys_i);
    #1 port_wake_event_i = 1;
    #1 chk(wake_msg_send_o, e);
    @(posedge clk_sys_i);
    #1 port_wake_event_i = 0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard, several times the length of the sequence
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 2000) err_total++;
    if (cyc == 2000) tally_and_finish;
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hfb56));
    repeat (12) @(posedge clk_sys_i);
    #1 rst_i = 0;
    acc(0, 12'h0c4, csr(0, 1, 0, 0), 0);
    acc(0, 12'h0c0, 32'hc803d001, 0);
    // Every code first, then random; lock is shut so the preserve bit stays
    for (int i = 0; i < 12; i++) begin
      n = (i < 4) ? 2'(i) : 2'($urandom);
      if (n == 2'h0 || n == 2'h3) s = n;
      acc(1, 12'h0c4, {30'h0, n}, 4'h1);
      acc(0, 12'h0c4, csr(s, 1, 0, 0), 0);
    end
    write_lock_open_i = 1;
    acc(1, 12'h0c4, 32'h3, 4'h1);
    acc(1, 12'h0c4, 32'h0, 4'h1);
    chk(context_reset_o, 1);
    acc(1, 12'h0c0, 32'h00200000, 4'hf);
    write_lock_open_i = 0;
    acc(1, 12'h0c0, 32'hffffffff, 4'hf);
    acc(0, 12'h0c0, 32'h0023d001, 0);
    wake(0);
    acc(0, 12'h0c4, csr(0, 0, 0, 1), 0);
    acc(1, 12'h0c4, 32'h100, 4'h2);
    wake(1);
    hot_rst_i = 1;
    @(posedge clk_sys_i);
    #1 hot_rst_i = 0;
    acc(0, 12'h0c4, csr(0, 1, 1, 1), 0);
    acc(0, 12'h0c0, 32'hc803d001, 0);
    acc(1, 12'h0c4, 32'h8100, 4'h2);
    acc(0, 12'h0c4, csr(0, 1, 1, 0), 0);
    // Wait out the synchroniser before judging the wake paths
    {d3cold_i, fwd_wake_msg_i} = 2'h3;
    repeat (8) @(posedge clk_sys_i);
    wake(0);
    chk(wake_msg_forward_o, 0);
    d3cold_i = 0;
    repeat (8) @(posedge clk_sys_i);
    repeat (6) begin
      #1 fwd_wake_msg_i = 1'($urandom);
      #1 chk(wake_msg_forward_o, fwd_wake_msg_i);
      @(posedge clk_sys_i);
    end
    tally_and_finish;
  end
endmodule // test_port_power_mgmt_regs
`default_nettype wire
